// >>> design/aph_pkg.sv
// constants and types for the converter parallel host port
package aph_pkg;
  localparam int APH_CLK_MHZ = 250;
  localparam int APH_RESULT_W = 12;
  localparam int APH_CFG_W = 8;
  localparam int APH_CFG_ACQ_BIT = 5;
  localparam logic [7:0] APH_CFG_RESET = 8'h00;
  localparam logic [11:0] APH_RESULT_RESET = 12'h000;
  // pin timing figures in ns
  localparam int APH_DONE_CLR_NS = 100;
  localparam int APH_DATA_VALID_NS = 70;
  localparam int APH_RD_RELEASE_NS = 70;
  localparam int APH_CS_RELEASE_NS = 100;
  // longest times round down to cycles
  localparam int APH_DONE_CLR_CYC = (APH_DONE_CLR_NS * APH_CLK_MHZ) / 1000;
  localparam int APH_DATA_VALID_CYC = (APH_DATA_VALID_NS * APH_CLK_MHZ) / 1000;
  localparam int APH_RD_RELEASE_CYC = (APH_RD_RELEASE_NS * APH_CLK_MHZ) / 1000;
  localparam int APH_CS_RELEASE_CYC = (APH_CS_RELEASE_NS * APH_CLK_MHZ) / 1000;
  // conversion length in conversion-clock cycles
  localparam int APH_CONV_CYCLES = 13;
  localparam int APH_ACQ_CYCLES = 3;
  localparam int APH_INT_CLK_DIV = 26;
  typedef enum logic [1:0] {APH_IDLE, APH_ACQ, APH_CONV} aph_state_t;
endpackage

// >>> design/aph_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module aph_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // async pins and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  // pins idle high after reset (strobes are active low)
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// >>> design/aph_host_port.sv
// parallel host port: strobes, config capture, conversion timing, done line, data bus
// Behaviour
// - while chip_select_n is low, drive conversion_done_n low once a conversion finished and its result is ready.
// - return conversion_done_n high within 100 ns after read_strobe_n falls.
// - present valid result data within 70 ns after read_strobe_n falls.
// - release the data bus within 70 ns after read_strobe_n rises.
// - release the data bus within 100 ns after chip_select_n rises.
// - the low eight data lines are bidirectional, the upper four output only.
// - conversion lasts a fixed count of conversion-clock cycles.
// - in internal acquisition a write rise with select low captures config and starts work.
// - in external acquisition the first write rise with select low starts conversion.
// - a read fall starts a bus read only while chip_select_n is low.
`timescale 1ns/1ps
module aph_host_port
  import aph_pkg::*;
#(
  parameter int CONV_CYCLES = APH_CONV_CYCLES,
  parameter int ACQ_CYCLES = APH_ACQ_CYCLES,
  parameter int INT_CLK_DIV = APH_INT_CLK_DIV
) (
  // system
  input wire logic clock,
  input wire logic reset,
  // host strobes
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic conv_clock_pin,
  input wire logic ext_clock_mode,
  // data lines: low eight bidirectional, upper four output only
  input wire logic [APH_CFG_W-1:0] data_low_in,
  output logic [APH_CFG_W-1:0] data_low_out,
  output logic [APH_CFG_W-1:0] data_low_oe,
  output logic [APH_RESULT_W-APH_CFG_W-1:0] data_high_out,
  output logic [APH_RESULT_W-APH_CFG_W-1:0] data_high_oe,
  // done line, output with enable
  output logic conversion_done_n_out,
  output logic conversion_done_n_oe,
  // converter core side
  input wire logic [APH_RESULT_W-1:0] core_result,
  output logic sample_hold,
  output logic [APH_CFG_W-1:0] config_byte
);
  import aph_pkg::*;

  logic [4:0] pins_s;
  logic cs_n_s, rd_n_s, wr_n_s, cclk_s, extm_s;
  logic rd_prev_r, wr_prev_r, cclk_prev_r;
  logic rd_prev_nxt, wr_prev_nxt, cclk_prev_nxt;
  logic rd_fall, wr_rise, cclk_fall;

  // strobes and mode pin come from outside; ext acq writes are raw data too
  aph_sync #(.WIDTH(5)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({chip_select_n, read_strobe_n, write_strobe_n, conv_clock_pin, ext_clock_mode}),
    .sync_out(pins_s)
  );
  assign {cs_n_s, rd_n_s, wr_n_s, cclk_s, extm_s} = pins_s;

  // config data sampled twice too; host holds it past the write rise
  logic [APH_CFG_W-1:0] din_m_r, din_s_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      din_m_r <= APH_CFG_RESET;
      din_s_r <= APH_CFG_RESET;
    end else begin
      din_m_r <= data_low_in;
      din_s_r <= din_m_r;
    end
  end

  // edge detection
  always_comb begin
    rd_prev_nxt = rd_n_s;
    wr_prev_nxt = wr_n_s;
    cclk_prev_nxt = cclk_s;
    rd_fall = rd_prev_r & ~rd_n_s;
    wr_rise = ~wr_prev_r & wr_n_s;
    cclk_fall = cclk_prev_r & ~cclk_s;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
      cclk_prev_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_prev_nxt;
      wr_prev_r <= wr_prev_nxt;
      cclk_prev_r <= cclk_prev_nxt;
    end
  end

  // internal conversion clock: a divider tick stands in for the clock fall
  logic [7:0] div_r, div_nxt;
  logic int_tick;
  always_comb begin
    int_tick = (div_r == 8'(INT_CLK_DIV - 1));
    div_nxt = int_tick ? 8'h00 : div_r + 8'h01;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end
  logic conv_tick;
  assign conv_tick = extm_s ? cclk_fall : int_tick;

  // conversion sequencer
  aph_state_t state_r, state_nxt;
  logic [APH_CFG_W-1:0] cfg_r, cfg_nxt;
  logic [APH_RESULT_W-1:0] result_r, result_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic ext_acq;
  // config bit 5 low selects internal acquisition
  assign ext_acq = cfg_r[APH_CFG_ACQ_BIT];

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    result_nxt = result_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (rd_fall && !cs_n_s) begin
      done_nxt = 1'b1;
    end
    case (state_r)
      APH_IDLE: begin
        // first write rise in external acq starts conversion
        if (wr_rise && !cs_n_s) begin
          cfg_nxt = din_s_r;
          cnt_nxt = 6'h00;
          if (ext_acq && din_s_r[APH_CFG_ACQ_BIT]) begin
            state_nxt = APH_CONV;
          end else if (din_s_r[APH_CFG_ACQ_BIT]) begin
            // entering external acq: wait in acquisition for the next write rise
            state_nxt = APH_ACQ;
          end else begin
            state_nxt = APH_ACQ;
          end
        end
      end
      APH_ACQ: begin
        if (ext_acq) begin
          if (wr_rise && !cs_n_s) begin
            state_nxt = APH_CONV;
            cnt_nxt = 6'h00;
          end
        end else if (conv_tick) begin
          // host keeps write high until this tick has passed
          if (cnt_r == 6'(ACQ_CYCLES - 1)) begin
            state_nxt = APH_CONV;
            cnt_nxt = 6'h00;
          end else begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
      end
      APH_CONV: begin
        if (conv_tick) begin
          if (cnt_r == 6'(CONV_CYCLES - 1)) begin
            state_nxt = APH_IDLE;
            result_nxt = core_result;
            // done goes low with the result
            done_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
      end
      default: state_nxt = APH_IDLE;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= APH_IDLE;
      cfg_r <= APH_CFG_RESET;
      result_r <= APH_RESULT_RESET;
      cnt_r <= 6'h00;
      done_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      result_r <= result_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  // bus drive: on from a read fall with select low, while both stay low
  logic drive_r, drive_nxt;
  logic [APH_RESULT_W-1:0] dout_r, dout_nxt;
  always_comb begin
    drive_nxt = drive_r;
    dout_nxt = dout_r;
    if (rd_fall && !cs_n_s) begin
      drive_nxt = 1'b1;
      // data registered on the read fall
      dout_nxt = result_r;
    end
    // release on read or select rise
    if (rd_n_s || cs_n_s) begin
      drive_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      drive_r <= 1'b0;
      dout_r <= APH_RESULT_RESET;
    end else begin
      drive_r <= drive_nxt;
      dout_r <= dout_nxt;
    end
  end

  // low byte shares lines with config input; high lines output only
  assign data_low_out = dout_r[APH_CFG_W-1:0];
  assign data_high_out = dout_r[APH_RESULT_W-1:APH_CFG_W];
  assign data_low_oe = {APH_CFG_W{drive_r}};
  assign data_high_oe = {(APH_RESULT_W - APH_CFG_W){drive_r}};
  // done line floats while select is high
  assign conversion_done_n_out = done_r;
  assign conversion_done_n_oe = ~cs_n_s;
  assign sample_hold = (state_r == APH_CONV);
  assign config_byte = cfg_r;
endmodule

// >>> dv/aph_host_port_sva.sv
// assertion checker for the converter parallel host port
`timescale 1ns/1ps
module aph_chk
  import aph_pkg::*;
#(
  parameter int CONV_CYCLES = APH_CONV_CYCLES,
  parameter int INT_CLK_DIV = APH_INT_CLK_DIV
) (
  // system and strobes
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic ext_clock_mode,
  // outputs watched
  input wire logic [APH_CFG_W-1:0] data_low_oe,
  input wire logic [APH_RESULT_W-APH_CFG_W-1:0] data_high_oe,
  input wire logic conversion_done_n_out,
  input wire logic conversion_done_n_oe,
  input wire logic sample_hold
);
  localparam int LO = (CONV_CYCLES - 1) * INT_CLK_DIV;
  localparam int HI = CONV_CYCLES * INT_CLK_DIV + 1;
  logic [15:0] hold_cnt;
  // free divider: first tick may come early
  always_ff @(posedge clock or posedge reset) begin
    if (reset) hold_cnt <= 16'h0;
    else hold_cnt <= sample_hold ? hold_cnt + 16'h1 : 16'h0;
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  property p_done_clr;
    $fell(read_strobe_n) && !chip_select_n |-> ##[1:4] conversion_done_n_out;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_drive;
    $fell(read_strobe_n) && !chip_select_n |-> ##[1:4] (&data_low_oe && &data_high_oe);
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");
  property p_rd_rel;
    $rose(read_strobe_n) |-> ##[1:4] (data_low_oe == 8'h00);
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("bus kept after read");
  property p_cs_rel;
    $rose(chip_select_n) |-> ##[1:4] (!data_low_oe && !data_high_oe && !conversion_done_n_oe);
  endproperty
  a_cs_rel: assert property (p_cs_rel) else $error("bus kept after deselect");
  property p_desel;
    chip_select_n [*4] |-> (data_low_oe == 8'h00 && data_high_oe == 4'h0);
  endproperty
  a_desel: assert property (p_desel) else $error("bus driven while deselected");
  property p_whole;
    |data_low_oe |-> (&data_low_oe && &data_high_oe);
  endproperty
  a_whole: assert property (p_whole) else $error("partial bus drive");
  property p_done_set;
    $fell(conversion_done_n_out) |-> $past(sample_hold);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done without conversion");
  property p_len;
    $fell(sample_hold) && !ext_clock_mode |-> hold_cnt >= LO && hold_cnt <= HI;
  endproperty
  a_len: assert property (p_len) else $error("conversion length off");
  c_done: cover property ($fell(conversion_done_n_out));
  c_read: cover property ($fell(read_strobe_n) && !chip_select_n);
  c_ext: cover property ($fell(sample_hold) && ext_clock_mode);
endmodule
bind aph_host_port aph_chk #(.CONV_CYCLES(CONV_CYCLES), .INT_CLK_DIV(INT_CLK_DIV)) u_chk (
  .clock(clock), .reset(reset), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .ext_clock_mode(ext_clock_mode),
  .data_low_oe(data_low_oe), .data_high_oe(data_high_oe),
  .conversion_done_n_out(conversion_done_n_out),
  .conversion_done_n_oe(conversion_done_n_oe), .sample_hold(sample_hold));

// >>> dv/aph_host_model.sv
// host model driving the parallel strobes
`timescale 1ns/1ps
module aph_host_model
  import aph_pkg::*;
(
  input wire logic clock,
  input wire logic ext_clock_mode,
  input wire logic [APH_CFG_W-1:0] data_low_out,
  input wire logic [APH_CFG_W-1:0] data_low_oe,
  input wire logic [APH_RESULT_W-APH_CFG_W-1:0] data_high_out,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic conv_clock_pin,
  output wire logic [APH_CFG_W-1:0] data_low_in
);
  logic drv = 1'b0;
  logic [APH_CFG_W-1:0] d_r = 8'h00;
  logic [2:0] div = 3'h0;
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    conv_clock_pin = 1'b0;
  end
  assign data_low_in = drv ? d_r : (data_low_oe[0] ? data_low_out : ~d_r);
  always @(posedge clock) begin
    div <= div + 3'h1;
    conv_clock_pin <= ext_clock_mode & div[2];
  end
  // strobe stays high after the write
  task automatic wr(input logic [APH_CFG_W-1:0] d);
    @(posedge clock);
    chip_select_n <= 1'b0;
    drv <= 1'b1;
    d_r <= d;
    write_strobe_n <= 1'b0;
    repeat (6) @(posedge clock);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clock);
    drv <= 1'b0;
    chip_select_n <= 1'b1;
  endtask
  task automatic rd(input logic cs, input logic cs_first, output logic [APH_RESULT_W-1:0] w);
    @(posedge clock);
    chip_select_n <= cs;
    read_strobe_n <= 1'b0;
    repeat (8) @(posedge clock);
    w = {data_high_out, data_low_out};
    if (cs_first) chip_select_n <= 1'b1;
    else read_strobe_n <= 1'b1;
    repeat (5) @(posedge clock);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
  endtask
endmodule

// >>> dv/aph_host_port_test.sv
// testbench for the converter parallel host port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module aph_host_port_test;
  import aph_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ext_clock_mode;
  logic [11:0] core_result;
  logic [11:0] w;
  logic cs_n, rd_n, wr_n, cclk, done_n, done_oe, hold;
  logic [7:0] dli, dlo, dloe, cfg;
  logic [3:0] dho, dhoe;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  aph_host_port #(.CONV_CYCLES(4), .ACQ_CYCLES(2), .INT_CLK_DIV(4)) DUT (
    .clock(clock), .reset(reset), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .conv_clock_pin(cclk), .ext_clock_mode(ext_clock_mode),
    .data_low_in(dli), .data_low_out(dlo), .data_low_oe(dloe), .data_high_out(dho),
    .data_high_oe(dhoe), .conversion_done_n_out(done_n), .conversion_done_n_oe(done_oe),
    .core_result(core_result), .sample_hold(hold), .config_byte(cfg));
  aph_host_model host (
    .clock(clock), .ext_clock_mode(ext_clock_mode), .data_low_out(dlo),
    .data_low_oe(dloe), .data_high_out(dho), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .conv_clock_pin(cclk),
    .data_low_in(dli));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 300 && done_n !== 1'b0; i++) @(posedge clock);
  endtask
  task automatic t_internal();
    core_result <= 12'ha5c;
    host.wr(8'h0b);
    wait_done();
    `CHK("done", 1'b0, done_n)
    `CHK("cfg", 8'h0b, cfg)
    host.rd(1'b1, 1'b0, w);
    `CHK("done", 1'b0, done_n)
    host.rd(1'b0, 1'b0, w);
    `CHK("word", 12'ha5c, w)
    `CHK("done", 1'b1, done_n)
    `CHK("oe", 8'h00, dloe)
    $display("test internal done");
  endtask
  task automatic t_external();
    ext_clock_mode <= 1'b1;
    core_result <= 12'h3c6;
    host.wr(8'h2b);
    `CHK("cfg", 8'h2b, cfg)
    repeat (60) @(posedge clock);
    `CHK("done", 1'b1, done_n)
    `CHK("hold", 1'b0, hold)
    host.wr(8'h2b);
    wait_done();
    `CHK("done", 1'b0, done_n)
    host.rd(1'b0, 1'b1, w);
    `CHK("word", 12'h3c6, w)
    `CHK("oe", 12'h000, {dhoe, dloe})
    `CHK("done oe", 1'b0, done_oe)
    $display("test external done");
  endtask
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    ext_clock_mode <= 1'b0;
    core_result <= 12'h000;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    `CHK("oe", 12'h000, {dhoe, dloe})
    t_internal();
    t_external();
    report_and_stop();
  end
endmodule
